// File: hw/dcr_regs.svh
// register offsets, field positions and reset values of the datapath
// configuration bank; included by the package user and the modules
`ifndef DCR_REGS_SVH
`define DCR_REGS_SVH

`define DCR_ADDR_W          7
`define DCR_OFS_CTRL        7'h02
`define DCR_OFS_SCALE       7'h03
`define DCR_CTRL_RESET      16'h7000
`define DCR_SCALE_RESET     16'hf000
`define DCR_CTRL_MASK       16'hf0fa
`define DCR_SCALE_MASK      16'hf001
`define DCR_MIDSCALE        16'h8000

`define DCR_BIT_WORD_WIDE   15
`define DCR_BIT_DACCLK_OFF  14
`define DCR_BIT_DATACLK_OFF 13
`define DCR_BIT_COLL_OFF    12
`define DCR_BIT_FOUR_WIRE   7
`define DCR_BIT_MIXER       6
`define DCR_BIT_MIX_GAIN    5
`define DCR_BIT_NCO         4
`define DCR_BIT_REVBUS      3
`define DCR_BIT_TWOS        1
`define DCR_BIT_TXEN        0
`define DCR_SCALE_HI        15
`define DCR_SCALE_LO        12

`endif

// File: hw/dcr_pkg.sv
// types shared by the datapath configuration bank
// assumes the offsets and fields come from dcr_regs.svh
package dcr_pkg;
    typedef logic [15:0] dcr_word_type;
endpackage : dcr_pkg

// File: hw/dcr_sample_path.sv
// one output lane: forces mid-scale while the output-kill alarm stands
// assumes the sample and the alarm are synchronous to CLK
`timescale 1ns/1ps
`include "dcr_regs.svh"
module dcr_sample_path
    import dcr_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         kill,
    input  wire dcr_word_type sample_in,
    output      dcr_word_type sample_out
);
    typedef struct packed {
        dcr_word_type q;
    } dcr_lane_type;

    dcr_lane_type state;
    dcr_lane_type next_state;

    always_comb begin
        next_state = state;
        next_state.q = kill ? `DCR_MIDSCALE : sample_in; // [R16]
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state <= '{q: `DCR_MIDSCALE};
        end else begin
            state <= next_state;
        end
    end

    assign sample_out = state.q;

    a_lane_midscale: assert property (@(posedge clk) disable iff (!rstn)
        kill |=> sample_out == 16'h8000) // [R16]
        else $error("lane not at mid-scale during kill");
endmodule : dcr_sample_path

// File: hw/dcr_config_bank.sv
// datapath control and output scale registers behind the serial port
// assumes the serial port decoder gives one write strobe per word
//
// How it works
// (R01) bit 15 picks word-wide or byte-wide input
// (R02) bit 14 lets conversion clock loss kill outputs
// (R03) bit 13 lets data clock loss kill outputs
// (R04) bit 12 lets fifo collision kill outputs
// (R05) software leaves source and kill alarms unmasked
// (R06) bit 7 picks four-wire serial port
// (R07) bit 6 enables the mixer
// (R08) bit 5 adds 6 dB mixer gain
// (R09) bit 4 enables oscillator, coarse mixing independent
// (R10) bit 3 reverses input bus bit order
// (R11) bit 1 selects two's complement input
// (R12) bits 15:12 set full-scale step, reset ones
// (R13) transmit on when register bit or pin high
// (R14) control register 0x02 resets to 0x7000
// (R15) scale register 0x03 resets to 0xf000
// (R16) output kill drives mid-scale 0x8000 everywhere
// (R17) reserved bits read zero, have no effect
`timescale 1ns/1ps
`include "dcr_regs.svh"
module dcr_config_bank
    import dcr_pkg::*;
(
    input  wire logic                   CLK,
    input  wire logic                   RSTN,
    input  wire logic                   WR_EN,
    input  wire logic                   RD_EN,
    input  wire logic [`DCR_ADDR_W-1:0] ADDR,
    input  wire dcr_word_type           WR_DATA,
    output      dcr_word_type           RD_DATA,
    input  wire logic                   TXENABLE_PIN,
    input  wire logic                   DACCLK_GONE,
    input  wire logic                   DATACLK_GONE,
    input  wire logic                   FIFO_COLLISION,
    input  wire logic                   SRC_DACCLK_UNMASKED,
    input  wire logic                   SRC_DATACLK_UNMASKED,
    input  wire logic                   SRC_COLL_UNMASKED,
    input  wire logic                   KILL_UNMASKED,
    input  wire dcr_word_type           SAMPLE_IN,
    output      dcr_word_type           SAMPLE_OUT,
    output      logic                   WORD_WIDE_INPUT,
    output      logic                   FOUR_WIRE_PORT_SEL,
    output      logic                   MIXER_EN,
    output      logic                   MIXER_GAIN_6DB,
    output      logic                   NCO_EN,
    output      logic                   REVERSE_BUS,
    output      logic                   TWOS_COMPLEMENT,
    output      logic [3:0]             FULL_SCALE_STEP,
    output      logic                   TX_ACTIVE,
    output      logic                   OUTPUT_KILL
);
    // =====================================================================
    // state
    typedef struct packed {
        dcr_word_type ctrl;
        dcr_word_type scale;
        dcr_word_type rd;
        logic         tx;
        logic         kill;
    } dcr_state_type;

    dcr_state_type state;
    dcr_state_type next_state;
    logic          kill_now;

    // =====================================================================
    // output kill: each source needs its enable and its unmasked alarm,
    // and the combined alarm must also be unmasked to reach the outputs
    always_comb begin
        kill_now = KILL_UNMASKED & (                            // [R05]
            (state.ctrl[`DCR_BIT_DACCLK_OFF] & DACCLK_GONE
                & SRC_DACCLK_UNMASKED)                          // [R02]
          | (state.ctrl[`DCR_BIT_DATACLK_OFF] & DATACLK_GONE
                & SRC_DATACLK_UNMASKED)                         // [R03]
          | (state.ctrl[`DCR_BIT_COLL_OFF] & FIFO_COLLISION
                & SRC_COLL_UNMASKED));                          // [R04]
    end

    // =====================================================================
    // register writes and reads
    always_comb begin
        next_state = state;
        // reserved bits are masked off so they never store a one
        if (WR_EN && ADDR == `DCR_OFS_CTRL) begin
            next_state.ctrl = WR_DATA & `DCR_CTRL_MASK;         // [R17]
        end
        if (WR_EN && ADDR == `DCR_OFS_SCALE) begin
            next_state.scale = WR_DATA & `DCR_SCALE_MASK;       // [R17]
        end
        if (RD_EN) begin
            unique case (ADDR)
                `DCR_OFS_CTRL:  next_state.rd = state.ctrl;
                `DCR_OFS_SCALE: next_state.rd = state.scale;
                default:        next_state.rd = 16'h0000;
            endcase
        end
        // pin is taken as is; either source enables the outputs
        next_state.tx = state.scale[`DCR_BIT_TXEN] | TXENABLE_PIN; // [R13]
        next_state.kill = kill_now;
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            state.ctrl  <= `DCR_CTRL_RESET;                     // [R14]
            state.scale <= `DCR_SCALE_RESET;                    // [R15]
            state.rd    <= 16'h0000;
            state.tx    <= 1'b0;
            state.kill  <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // =====================================================================
    // outputs, each straight from a flip-flop
    assign RD_DATA            = state.rd;
    assign WORD_WIDE_INPUT    = state.ctrl[`DCR_BIT_WORD_WIDE];  // [R01]
    assign FOUR_WIRE_PORT_SEL = state.ctrl[`DCR_BIT_FOUR_WIRE];  // [R06]
    assign MIXER_EN           = state.ctrl[`DCR_BIT_MIXER];      // [R07]
    assign MIXER_GAIN_6DB     = state.ctrl[`DCR_BIT_MIX_GAIN];   // [R08]
    // coarse mixing uses MIXER_EN only, not NCO_EN
    assign NCO_EN             = state.ctrl[`DCR_BIT_NCO];        // [R09]
    assign REVERSE_BUS        = state.ctrl[`DCR_BIT_REVBUS];     // [R10]
    assign TWOS_COMPLEMENT    = state.ctrl[`DCR_BIT_TWOS];       // [R11]
    assign FULL_SCALE_STEP    =
        state.scale[`DCR_SCALE_HI:`DCR_SCALE_LO];               // [R12]
    assign TX_ACTIVE          = state.tx;
    assign OUTPUT_KILL        = state.kill;

    // =====================================================================
    // sample lane, one register stage behind the kill flag
    dcr_sample_path u_lane (
        .clk        (CLK),
        .rstn       (RSTN),
        .kill       (state.kill),                               // [R16]
        .sample_in  (SAMPLE_IN),
        .sample_out (SAMPLE_OUT)
    );

    // =====================================================================
    // checks: reset values
    a_ctrl_reset: assert property (@(posedge CLK) // [R14]
        !RSTN |=> state.ctrl == 16'h7000)
        else $error("control register reset value wrong");
    a_scale_reset: assert property (@(posedge CLK) // [R15]
        !RSTN |=> FULL_SCALE_STEP == 4'hf && !state.scale[0])
        else $error("scale register reset value wrong");

    // =====================================================================
    // checks: a write shows on the outputs one edge after it is taken
    a_ctrl_write: assert property (@(posedge CLK) // [R17]
        disable iff (!RSTN)
        WR_EN && ADDR == 7'h02 ##1 RD_EN && ADDR == 7'h02 && !WR_EN
        |=> RD_DATA == ($past(WR_DATA, 2) & 16'hf0fa))
        else $error("control write not read back");
    a_rsvd_zero: assert property (@(posedge CLK) // [R17]
        disable iff (!RSTN)
        (state.ctrl & 16'h0f05) == 16'h0000
        && (state.scale & 16'h0ffe) == 16'h0000)
        else $error("reserved bit holds a one");
    a_word_wide: assert property (@(posedge CLK) // [R01]
        disable iff (!RSTN)
        WR_EN && ADDR == 7'h02 |=> WORD_WIDE_INPUT == $past(WR_DATA[15]))
        else $error("word width bit not applied");
    a_four_wire: assert property (@(posedge CLK) // [R06]
        disable iff (!RSTN)
        WR_EN && ADDR == 7'h02 |=> FOUR_WIRE_PORT_SEL == $past(WR_DATA[7]))
        else $error("four-wire select not applied");
    a_mixer_on: assert property (@(posedge CLK) // [R07]
        disable iff (!RSTN)
        WR_EN && ADDR == 7'h02 |=> MIXER_EN == $past(WR_DATA[6]))
        else $error("mixer enable not applied");
    a_mixer_gain: assert property (@(posedge CLK) // [R08]
        disable iff (!RSTN)
        WR_EN && ADDR == 7'h02 |=> MIXER_GAIN_6DB == $past(WR_DATA[5]))
        else $error("mixer gain bit not applied");
    a_nco_on: assert property (@(posedge CLK) // [R09]
        disable iff (!RSTN)
        WR_EN && ADDR == 7'h02 |=> NCO_EN == $past(WR_DATA[4]))
        else $error("oscillator enable not applied");
    a_bus_reverse: assert property (@(posedge CLK) // [R10]
        disable iff (!RSTN)
        WR_EN && ADDR == 7'h02 |=> REVERSE_BUS == $past(WR_DATA[3]))
        else $error("bus reversal bit not applied");
    a_twos_format: assert property (@(posedge CLK) // [R11]
        disable iff (!RSTN)
        WR_EN && ADDR == 7'h02 |=> TWOS_COMPLEMENT == $past(WR_DATA[1]))
        else $error("sample format bit not applied");
    a_step_write: assert property (@(posedge CLK) // [R12]
        disable iff (!RSTN)
        WR_EN && ADDR == 7'h03 |=> FULL_SCALE_STEP == $past(WR_DATA[15:12]))
        else $error("full-scale step not applied");
    // the last reset edge must not start an attempt: its flop was cleared
    a_tx_or: assert property (@(posedge CLK) // [R13]
        disable iff (!RSTN)
        RSTN |=> TX_ACTIVE == ($past(TXENABLE_PIN) | $past(state.scale[0])))
        else $error("transmit enable not pin or bit");

    // =====================================================================
    // checks: alarm shutdown, one edge to the flag, one more to the lane
    a_dacclk_kill: assert property (@(posedge CLK) // [R02]
        disable iff (!RSTN)
        RSTN && DACCLK_GONE && state.ctrl[14] && SRC_DACCLK_UNMASKED
        && KILL_UNMASKED |=> OUTPUT_KILL ##1 SAMPLE_OUT == 16'h8000)
        else $error("clock loss did not kill outputs");
    a_dataclk_kill: assert property (@(posedge CLK) // [R03]
        disable iff (!RSTN)
        RSTN && DATACLK_GONE && state.ctrl[13] && SRC_DATACLK_UNMASKED
        && KILL_UNMASKED |=> OUTPUT_KILL)
        else $error("data clock loss did not kill");
    a_coll_kill: assert property (@(posedge CLK) // [R04]
        disable iff (!RSTN)
        RSTN && FIFO_COLLISION && state.ctrl[12] && SRC_COLL_UNMASKED
        && KILL_UNMASKED |=> OUTPUT_KILL)
        else $error("fifo collision did not kill");
    a_coll_gate: assert property (@(posedge CLK) // [R04]
        disable iff (!RSTN)
        !state.ctrl[12] && !DACCLK_GONE && !DATACLK_GONE |=> !OUTPUT_KILL)
        else $error("collision killed while disabled");
    a_mask_gate: assert property (@(posedge CLK) // [R05]
        disable iff (!RSTN)
        !KILL_UNMASKED |=> !OUTPUT_KILL)
        else $error("kill passed a masked alarm");

    // =====================================================================
    // scenarios worth seeing
    c_kill: cover property (@(posedge CLK) disable iff (!RSTN)
        OUTPUT_KILL ##1 !OUTPUT_KILL);
    c_write_ctrl: cover property (@(posedge CLK) disable iff (!RSTN)
        WR_EN && ADDR == 7'h02);
    c_tx_pin_only: cover property (@(posedge CLK) disable iff (!RSTN)
        TXENABLE_PIN && !state.scale[0] ##1 TX_ACTIVE);
    c_readback: cover property (@(posedge CLK) disable iff (!RSTN)
        WR_EN && ADDR == 7'h02 ##1 RD_EN && ADDR == 7'h02);
    c_coll_kill: cover property (@(posedge CLK) disable iff (!RSTN)
        FIFO_COLLISION && state.ctrl[12] ##1 OUTPUT_KILL);
endmodule : dcr_config_bank

// File: tb/tb_top.sv
// self-checking bench for the datapath configuration bank
// assumes dcr_regs.svh is on the include path and the design compiled first
`timescale 1ns/1ps
`include "dcr_regs.svh"
module tb_top import dcr_pkg::*;;
    logic         clk      = 1'b0;
    logic         rstn     = 1'b0;
    logic         wr_en    = 1'b0;
    logic         rd_en    = 1'b0;
    logic         pin      = 1'b0;
    logic         kill_unm = 1'b0;
    logic [6:0]   addr     = 7'h00;
    logic [2:0]   gone     = 3'h0;
    logic [2:0]   src_unm  = 3'h0;
    dcr_word_type wr_data  = 16'h0000;
    dcr_word_type smp      = 16'h1234;
    dcr_word_type rd_data, sample_out, rv;
    logic [3:0]   step;
    logic         ww, fw, mx, mg, nco, rev, twos, tx, kill;
    int           failures  = 0;
    int           tests_run = 0;
    // control word rebuilt from the outputs; bits 14:12 have no output
    wire dcr_word_type cfg = {ww, 7'h00, fw, mx, mg, nco, rev, 1'b0,
                              twos, 1'b0};

    always #4 clk = ~clk;

    dcr_config_bank dcr_config_bank_i (.CLK(clk), .RSTN(rstn), .WR_EN(wr_en),
        .RD_EN(rd_en), .ADDR(addr), .WR_DATA(wr_data), .RD_DATA(rd_data),
        .TXENABLE_PIN(pin), .DACCLK_GONE(gone[0]), .DATACLK_GONE(gone[1]),
        .FIFO_COLLISION(gone[2]), .SRC_DACCLK_UNMASKED(src_unm[0]),
        .SRC_DATACLK_UNMASKED(src_unm[1]), .SRC_COLL_UNMASKED(src_unm[2]),
        .KILL_UNMASKED(kill_unm), .SAMPLE_IN(smp), .SAMPLE_OUT(sample_out),
        .WORD_WIDE_INPUT(ww), .FOUR_WIRE_PORT_SEL(fw), .MIXER_EN(mx),
        .MIXER_GAIN_6DB(mg), .NCO_EN(nco), .REVERSE_BUS(rev),
        .TWOS_COMPLEMENT(twos), .FULL_SCALE_STEP(step), .TX_ACTIVE(tx),
        .OUTPUT_KILL(kill));

    // ==========================================
    // helpers
    task check(input dcr_word_type seen, input dcr_word_type exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task wr(input logic [6:0] a, input dcr_word_type d);
        @(posedge clk);
        wr_en   <= 1'b1;
        addr    <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask : wr

    task rd(input logic [6:0] a, output dcr_word_type d);
        @(posedge clk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
    endtask : rd

    task summarize;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    // ==========================================
    // scenarios
    task test_reset;
        rd(`DCR_OFS_CTRL, rv);
        check(rv, 16'h7000);
        rd(`DCR_OFS_SCALE, rv);
        check(rv, 16'hf000);
        check({step, 11'h000, tx}, 16'hf000);
        check(cfg, 16'h0000);
        wr(7'h05, 16'hffff);
        rd(7'h05, rv);
        check(rv, 16'h0000);
        rd(`DCR_OFS_CTRL, rv);
        check(rv, 16'h7000);
        $display("test reset done");
    endtask : test_reset

    task test_ctrl;
        wr(`DCR_OFS_CTRL, 16'hffff);
        check(cfg, 16'h80fa);
        rd(`DCR_OFS_CTRL, rv);
        check(rv, 16'hf0fa);
        for (int b = 0; b < 16; b++) begin
            wr(`DCR_OFS_CTRL, 16'h0001 << b);
            check(cfg, (16'h0001 << b) & 16'h80fa);
        end
        $display("test ctrl done");
    endtask : test_ctrl

    task test_tx;
        for (int i = 0; i < 4; i++) begin
            wr(`DCR_OFS_SCALE, {4'(i + 9), 11'h7ff, i[0]});
            @(posedge clk);
            pin <= i[1];
            repeat (2) @(posedge clk);
            #1;
            rv = {4'(i + 9), 11'h000, i[0] | i[1]};
            check({step, 11'h000, tx}, rv);
            rd(`DCR_OFS_SCALE, rv);
            check(rv, {4'(i + 9), 11'h000, i[0]});
        end
        $display("test tx done");
    endtask : test_tx

    // one alarm source with its enable, source mask and kill mask chosen
    task kill_case(input int i, input logic s, input logic k, input logic en);
        wr(`DCR_OFS_CTRL, en ? 16'h7000 : 16'h7000 & ~(16'h4000 >> i));
        @(posedge clk);
        gone[i]    <= 1'b1;
        src_unm[i] <= s;
        kill_unm   <= k;
        repeat (3) @(posedge clk);
        #1;
        check(16'(kill), 16'(s & k & en));
        check(sample_out, (s & k & en) ? 16'h8000 : smp);
        @(posedge clk);
        gone[i] <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check(sample_out, smp);
    endtask : kill_case

    task test_kill;
        for (int i = 0; i < 3; i++) begin
            kill_case(i, 1'b1, 1'b1, 1'b1);
            kill_case(i, 1'b0, 1'b1, 1'b1);
            kill_case(i, 1'b1, 1'b0, 1'b1);
            kill_case(i, 1'b1, 1'b1, 1'b0);
        end
        $display("test kill done");
    endtask : test_kill

    // write and read on one edge, then read again: old word, then new
    task test_b2b;
        @(posedge clk);
        wr_en   <= 1'b1;
        rd_en   <= 1'b1;
        addr    <= `DCR_OFS_CTRL;
        wr_data <= 16'h5a5a;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
        check(rd_data, 16'h7000);
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        check(rd_data, 16'h505a);
        check(cfg, 16'h005a);
        $display("test b2b done");
    endtask : test_b2b

    // a second reset in mid-run brings both registers back
    task test_rerun;
        wr(`DCR_OFS_CTRL, 16'h80fa);
        wr(`DCR_OFS_SCALE, 16'h0001);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        #1;
        check({step, 11'h000, tx}, 16'hf000);
        check(cfg, 16'h0000);
        rd(`DCR_OFS_CTRL, rv);
        check(rv, 16'h7000);
        $display("test rerun done");
    endtask : test_rerun

    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        test_reset;
        test_b2b;
        test_ctrl;
        test_tx;
        test_kill;
        test_rerun;
        summarize;
    end

    // whole run needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk);
        failures++;
        summarize;
    end
endmodule : tb_top
